// ===== src/pio_pkg.sv
/*
 * shared constants and carrier types for the parallel i/o port block.
 * assumes a single bus clock and an axi4-lite master issuing word accesses.
 */
package pio_pkg;

    localparam int unsigned PIO_ADDR_W = 8;
    localparam int unsigned PIO_DATA_W = 32;
    localparam int unsigned PIO_PINS   = 21;

    // register indices; byte address is four times the index
    localparam logic [3:0] PIO_IDX_A_LATCH = 4'h0;
    localparam logic [3:0] PIO_IDX_B_LATCH = 4'h1;
    localparam logic [3:0] PIO_IDX_C_LATCH = 4'h2;
    localparam logic [3:0] PIO_IDX_D_LATCH = 4'h3;
    localparam logic [3:0] PIO_IDX_A_DIR   = 4'h4;
    localparam logic [3:0] PIO_IDX_B_DIR   = 4'h5;
    localparam logic [3:0] PIO_IDX_C_DIR   = 4'h6;
    localparam logic [3:0] PIO_IDX_D_DIR   = 4'h7;
    localparam logic [3:0] PIO_IDX_E_LATCH = 4'h8;
    localparam logic [3:0] PIO_IDX_E_DIR   = 4'hc;
    localparam logic [3:0] PIO_IDX_A_PUE   = 4'hd;
    localparam logic [3:0] PIO_IDX_C_PUE   = 4'he;
    localparam logic [3:0] PIO_IDX_D_PUE   = 4'hf;

    // implemented widths per port
    localparam int unsigned PIO_W_A = 4;
    localparam int unsigned PIO_W_B = 6;
    localparam int unsigned PIO_W_C = 2;
    localparam int unsigned PIO_W_D = 7;
    localparam int unsigned PIO_W_E = 2;

    // values after reset
    localparam logic [7:0] PIO_DIR_RST = 8'h00;
    localparam logic [7:0] PIO_PUE_RST = 8'h00;

    // axi response codes
    localparam logic [1:0] PIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

    // timer edge select value that leaves the pin to the port
    localparam logic [1:0] PIO_EDGE_OFF = 2'h0;

    typedef struct packed {
        logic [1:0] e;
        logic [6:0] d;
        logic [1:0] c;
        logic [5:0] b;
        logic [3:0] a;
    } pio_pins_t;

    typedef struct packed {
        logic [3:0] keyboard_irq_pin_enable;
        logic       adc_active;
        logic [2:0] adc_channel_select;
        logic       spi_module_enable;
        logic [1:0] timer_ch0_edge_select;
        logic [1:0] timer_ch1_edge_select;
        logic [1:0] timer_two_ch0_edge_select;
        logic       sci_module_enable;
    } pio_periph_t;

endpackage

// ===== src/pio_port.sv
/*
 * per-port pin control: drive, enable, pullup and read-back selection.
 * assumes latch, direction and takeover masks are on the aclk domain.
 */
module pio_port
    import pio_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] pue,
    input  wire logic [W-1:0] take,
    input  wire logic [W-1:0] hold_in,
    input  wire logic [W-1:0] analog,
    input  wire logic [W-1:0] per_out,
    input  wire logic [W-1:0] per_oe,
    input  wire logic [W-1:0] pin_level,
    output logic      [W-1:0] out_reg,
    output logic      [W-1:0] oe_reg,
    output logic      [W-1:0] pu_reg,
    output logic      [W-1:0] rd
);
    logic [W-1:0] oe_next;
    logic [W-1:0] out_next;
    logic [W-1:0] pu_next;

    always_comb begin
        oe_next  = take & per_oe | ~take & ~hold_in & ~analog & dir;
        out_next = oe_next & (take & per_out | ~take & latch);
        pu_next  = pue & ~dir & ~oe_next & ~take & ~analog;
        rd       = dir & latch | ~dir & pin_level;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg <= '0;
            oe_reg  <= '0;
            pu_reg  <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
            pu_reg  <= pu_next;
        end
    end
endmodule

// ===== src/pio_sync.sv
/*
 * three-stage input synchroniser; the output follows once stages two and
 * three agree. assumes inputs are asynchronous to aclk.
 */
module pio_sync
    import pio_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

// ===== src/pio_top.sv
/*
 * five parallel i/o ports behind an axi4-lite slave, with peripheral pin
 * takeover. assumes external pad logic resolves pin_out/pin_oe/pin_pullup.
 */
module pio_top
    import pio_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [PIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [PIO_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [PIO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [PIO_DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire pio_periph_t           periph_ctl,
    input  wire pio_pins_t             periph_out,
    input  wire pio_pins_t             periph_oe,
    input  wire pio_pins_t             pin_in,
    output pio_pins_t                  pin_out,
    output pio_pins_t                  pin_oe,
    output pio_pins_t                  pin_pullup,
    output pio_pins_t                  pin_level
);
    // software registers
    logic [PIO_W_A-1:0] port_a_latch_reg;
    logic [PIO_W_B-1:0] port_b_latch_reg;
    logic [PIO_W_C-1:0] port_c_latch_reg;
    logic [PIO_W_D-1:0] port_d_latch_reg;
    logic [PIO_W_E-1:0] port_e_latch_reg;
    logic [PIO_W_A-1:0] port_a_direction_reg;
    logic [PIO_W_B-1:0] port_b_direction_reg;
    logic [PIO_W_C-1:0] port_c_direction_reg;
    logic [PIO_W_D-1:0] port_d_direction_reg;
    logic [PIO_W_E-1:0] port_e_direction_reg;
    logic [PIO_W_A-1:0] port_a_pullup_enable_reg;
    logic [PIO_W_C-1:0] port_c_pullup_enable_reg;
    logic [PIO_W_D-1:0] port_d_pullup_enable_reg;

    // bus state
    logic                  awready_reg;
    logic                  wready_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  arready_reg;
    logic                  rvalid_reg;
    logic [1:0]            rresp_reg;
    logic [PIO_DATA_W-1:0] rdata_reg;
    logic [PIO_ADDR_W-1:0] wr_addr_reg;
    logic [7:0]            wr_byte_reg;
    logic                  wr_lane_reg;
    logic                  wr_fire;
    logic                  wr_ok;
    logic [3:0]            wr_idx;

    // pin side
    pio_pins_t take_mask;
    pio_pins_t hold_mask;
    pio_pins_t analog_mask;
    pio_pins_t rd_val;
    logic [PIO_W_B-1:0] adc_sel;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    function automatic logic addr_mapped(input logic [PIO_ADDR_W-1:0] a);
        logic [3:0] idx;
        idx = a[5:2];
        addr_mapped = (a[PIO_ADDR_W-1:6] == '0) && ((idx <= PIO_IDX_E_LATCH)
                      || (idx >= PIO_IDX_E_DIR));
    endfunction

    function automatic logic [7:0] read_byte(input logic [3:0] idx);
        read_byte = 8'h00;
        case (idx)
            PIO_IDX_A_LATCH: read_byte[PIO_W_A-1:0] = rd_val.a;
            PIO_IDX_B_LATCH: read_byte[PIO_W_B-1:0] = rd_val.b;
            PIO_IDX_C_LATCH: read_byte[PIO_W_C-1:0] = rd_val.c;
            PIO_IDX_D_LATCH: read_byte[PIO_W_D-1:0] = rd_val.d;
            PIO_IDX_E_LATCH: read_byte[PIO_W_E-1:0] = rd_val.e;
            PIO_IDX_A_DIR:   read_byte[PIO_W_A-1:0] = port_a_direction_reg;
            PIO_IDX_B_DIR:   read_byte[PIO_W_B-1:0] = port_b_direction_reg;
            PIO_IDX_C_DIR:   read_byte[PIO_W_C-1:0] = port_c_direction_reg;
            PIO_IDX_D_DIR:   read_byte[PIO_W_D-1:0] = port_d_direction_reg;
            PIO_IDX_E_DIR:   read_byte[PIO_W_E-1:0] = port_e_direction_reg;
            PIO_IDX_A_PUE:   read_byte[PIO_W_A-1:0] = port_a_pullup_enable_reg;
            PIO_IDX_C_PUE:   read_byte[PIO_W_C-1:0] = port_c_pullup_enable_reg;
            PIO_IDX_D_PUE:   read_byte[PIO_W_D-1:0] = port_d_pullup_enable_reg;
            default:         read_byte = 8'h00;
        endcase
    endfunction

    // write channel handshakes: address and data may arrive in either order
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_idx  = wr_addr_reg[5:2];
    assign wr_ok   = addr_mapped(wr_addr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
        end else if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_addr_reg <= '0;
        end else if (s_axi_awvalid && awready_reg) begin
            wr_addr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg  <= 1'b1;
            wr_byte_reg <= 8'h00;
            wr_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && wready_reg) begin
            wready_reg  <= 1'b0;
            wr_byte_reg <= s_axi_wdata[7:0];
            wr_lane_reg <= s_axi_wstrb[0];
        end else if (bvalid_reg && s_axi_bready) begin
            wready_reg  <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= PIO_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // data latches keep their contents through reset
    always_ff @(posedge aclk) begin
        if (wr_fire && wr_ok && wr_lane_reg) begin
            case (wr_idx)
                PIO_IDX_A_LATCH: port_a_latch_reg <= wr_byte_reg[PIO_W_A-1:0];
                PIO_IDX_B_LATCH: port_b_latch_reg <= wr_byte_reg[PIO_W_B-1:0];
                PIO_IDX_C_LATCH: port_c_latch_reg <= wr_byte_reg[PIO_W_C-1:0];
                PIO_IDX_D_LATCH: port_d_latch_reg <= wr_byte_reg[PIO_W_D-1:0];
                PIO_IDX_E_LATCH: port_e_latch_reg <= wr_byte_reg[PIO_W_E-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_direction_reg <= PIO_DIR_RST[PIO_W_A-1:0];
            port_b_direction_reg <= PIO_DIR_RST[PIO_W_B-1:0];
            port_c_direction_reg <= PIO_DIR_RST[PIO_W_C-1:0];
            port_d_direction_reg <= PIO_DIR_RST[PIO_W_D-1:0];
            port_e_direction_reg <= PIO_DIR_RST[PIO_W_E-1:0];
        end else if (wr_fire && wr_ok && wr_lane_reg) begin
            case (wr_idx)
                PIO_IDX_A_DIR: port_a_direction_reg <= wr_byte_reg[PIO_W_A-1:0];
                PIO_IDX_B_DIR: port_b_direction_reg <= wr_byte_reg[PIO_W_B-1:0];
                PIO_IDX_C_DIR: port_c_direction_reg <= wr_byte_reg[PIO_W_C-1:0];
                PIO_IDX_D_DIR: port_d_direction_reg <= wr_byte_reg[PIO_W_D-1:0];
                PIO_IDX_E_DIR: port_e_direction_reg <= wr_byte_reg[PIO_W_E-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_pullup_enable_reg <= PIO_PUE_RST[PIO_W_A-1:0];
            port_c_pullup_enable_reg <= PIO_PUE_RST[PIO_W_C-1:0];
            port_d_pullup_enable_reg <= PIO_PUE_RST[PIO_W_D-1:0];
        end else if (wr_fire && wr_ok && wr_lane_reg) begin
            case (wr_idx)
                PIO_IDX_A_PUE: port_a_pullup_enable_reg <= wr_byte_reg[PIO_W_A-1:0];
                PIO_IDX_C_PUE: port_c_pullup_enable_reg <= wr_byte_reg[PIO_W_C-1:0];
                PIO_IDX_D_PUE: port_d_pullup_enable_reg <= wr_byte_reg[PIO_W_D-1:0];
                default: ;
            endcase
        end
    end

    // read channel: data registered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= PIO_RESP_OKAY;
            rdata_reg   <= '0;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= addr_mapped(s_axi_araddr) ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
            rdata_reg   <= addr_mapped(s_axi_araddr)
                           ? {24'h000000, read_byte(s_axi_araddr[5:2])} : '0;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // peripheral takeover masks
    always_comb begin
        adc_sel = '0;
        if (periph_ctl.adc_active && (periph_ctl.adc_channel_select < 3'(PIO_W_B))) begin
            adc_sel[periph_ctl.adc_channel_select] = 1'b1;
        end
        take_mask   = '0;
        hold_mask   = '0;
        analog_mask = '0;
        hold_mask.a = periph_ctl.keyboard_irq_pin_enable;
        analog_mask.b = adc_sel;
        take_mask.d[3:0] = {4{periph_ctl.spi_module_enable}};
        take_mask.d[4] = periph_ctl.timer_ch0_edge_select != PIO_EDGE_OFF;
        take_mask.d[5] = periph_ctl.timer_ch1_edge_select != PIO_EDGE_OFF;
        take_mask.d[6] = periph_ctl.timer_two_ch0_edge_select != PIO_EDGE_OFF;
        take_mask.e = {2{periph_ctl.sci_module_enable}};
    end

    pio_sync #(.W(PIO_PINS)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .level    (pin_level)
    );

    // one controller per port
    pio_port #(.W(PIO_W_A)) u_port_a (
        .aclk (aclk), .aresetn (aresetn),
        .latch (port_a_latch_reg), .dir (port_a_direction_reg),
        .pue (port_a_pullup_enable_reg),
        .take (take_mask.a), .hold_in (hold_mask.a), .analog (analog_mask.a),
        .per_out (periph_out.a), .per_oe (periph_oe.a), .pin_level (pin_level.a),
        .out_reg (pin_out.a), .oe_reg (pin_oe.a), .pu_reg (pin_pullup.a), .rd (rd_val.a)
    );

    pio_port #(.W(PIO_W_B)) u_port_b (
        .aclk (aclk), .aresetn (aresetn),
        .latch (port_b_latch_reg), .dir (port_b_direction_reg),
        .pue ('0),
        .take (take_mask.b), .hold_in (hold_mask.b), .analog (analog_mask.b),
        .per_out (periph_out.b), .per_oe (periph_oe.b), .pin_level (pin_level.b),
        .out_reg (pin_out.b), .oe_reg (pin_oe.b), .pu_reg (pin_pullup.b), .rd (rd_val.b)
    );

    pio_port #(.W(PIO_W_C)) u_port_c (
        .aclk (aclk), .aresetn (aresetn),
        .latch (port_c_latch_reg), .dir (port_c_direction_reg),
        .pue (port_c_pullup_enable_reg),
        .take (take_mask.c), .hold_in (hold_mask.c), .analog (analog_mask.c),
        .per_out (periph_out.c), .per_oe (periph_oe.c), .pin_level (pin_level.c),
        .out_reg (pin_out.c), .oe_reg (pin_oe.c), .pu_reg (pin_pullup.c), .rd (rd_val.c)
    );

    pio_port #(.W(PIO_W_D)) u_port_d (
        .aclk (aclk), .aresetn (aresetn),
        .latch (port_d_latch_reg), .dir (port_d_direction_reg),
        .pue (port_d_pullup_enable_reg),
        .take (take_mask.d), .hold_in (hold_mask.d), .analog (analog_mask.d),
        .per_out (periph_out.d), .per_oe (periph_oe.d), .pin_level (pin_level.d),
        .out_reg (pin_out.d), .oe_reg (pin_oe.d), .pu_reg (pin_pullup.d), .rd (rd_val.d)
    );

    pio_port #(.W(PIO_W_E)) u_port_e (
        .aclk (aclk), .aresetn (aresetn),
        .latch (port_e_latch_reg), .dir (port_e_direction_reg),
        .pue ('0),
        .take (take_mask.e), .hold_in (hold_mask.e), .analog (analog_mask.e),
        .per_out (periph_out.e), .per_oe (periph_oe.e), .pin_level (pin_level.e),
        .out_reg (pin_out.e), .oe_reg (pin_oe.e), .pu_reg (pin_pullup.e), .rd (rd_val.e)
    );
endmodule

// ===== tb/pio_monitor.sv
/*
 * checker for the port block: pin drive, pullup and takeover relations
 * and bus answers. assumes it is bound onto pio_top, one aclk domain.
 */
module pio_monitor
    import pio_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire pio_periph_t periph_ctl,
    input wire pio_pins_t   periph_oe,
    input wire pio_pins_t   pin_out,
    input wire pio_pins_t   pin_oe,
    input wire pio_pins_t   pin_pullup
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_idle_a: assert property ($rose(aresetn) |-> pin_oe == '0 && pin_pullup == '0)
        else $error("pins active after reset");
    pullup_output_a: assert property ((pin_pullup & pin_oe) == '0)
        else $error("pullup on a driven pin");
    pullup_ports_a: assert property (pin_pullup.b == '0 && pin_pullup.e == '0)
        else $error("pullup on port without pullups");
    drive_gated_a: assert property ((pin_out & ~pin_oe) == '0)
        else $error("drive value without enable");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    read_upper_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == '0)
        else $error("read upper bits set");
    keyboard_take_a: assert property (periph_ctl.keyboard_irq_pin_enable != '0 |=>
        (pin_oe.a & $past(periph_ctl.keyboard_irq_pin_enable)) == '0)
        else $error("keyboard pin still driven");
    adc_take_a: assert property (periph_ctl.adc_active && periph_ctl.adc_channel_select < 3'h6
        |=> pin_oe.b[$past(periph_ctl.adc_channel_select)] == 1'b0)
        else $error("analog pin still driven");
    spi_take_a: assert property (periph_ctl.spi_module_enable |=>
        pin_oe.d[3:0] == $past(periph_oe.d[3:0]) && pin_pullup.d[3:0] == '0)
        else $error("spi pins not handed over");
    sci_take_a: assert property (periph_ctl.sci_module_enable |=> pin_oe.e == $past(periph_oe.e))
        else $error("sci pins not handed over");
endmodule

bind pio_top pio_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .periph_ctl, .periph_oe, .pin_out, .pin_oe, .pin_pullup);

// ===== tb/pio_pad_model.sv
/*
 * pad model: block drive wins, then an outside driver, then the pullup;
 * a floating pin toggles every cycle. assumes the bench sets ext_*.
 */
module pio_pad_model
    import pio_pkg::*;
(
    input  wire logic      aclk,
    input  wire pio_pins_t pin_out,
    input  wire pio_pins_t pin_oe,
    input  wire pio_pins_t pin_pullup,
    input  wire pio_pins_t ext_drive,
    input  wire pio_pins_t ext_oe,
    output pio_pins_t      pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    pio_pins_t float_q = '0;
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_drive)
               | (~pin_oe & ~ext_oe & (pin_pullup | float_q));
    end
endmodule

// ===== tb/tb_top.sv
/*
 * bench for pio_top: register traffic, pad levels, peripheral takeover.
 * assumes pio_pad_model on the pins and pio_monitor bound to the block.
 */
module tb_top
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = '0;
    logic [7:0]  s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    pio_periph_t periph_ctl = '0;
    pio_pins_t   periph_out = '0;
    pio_pins_t   periph_oe = '0;
    pio_pins_t   ext_drive = '0;
    pio_pins_t   ext_oe = '0;
    pio_pins_t   pin_in, pin_out, pin_oe, pin_pullup, pin_level;
    logic [31:0] lfsr = 32'hadb0838a;
    logic [33:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [7:0]  lat[5];
    logic [3:0]  li[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
    logic [3:0]  di[5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc};
    logic [7:0]  mk[5] = '{8'h0f, 8'h3f, 8'h03, 8'h7f, 8'h03};
    logic [7:0]  bad[5] = '{8'h24, 8'h28, 8'h2c, 8'h40, 8'hc0};
    int          n_mismatch = 0;
    int          checks = 0;

    pio_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .periph_ctl, .periph_out, .periph_oe, .pin_in, .pin_out, .pin_oe,
        .pin_pullup, .pin_level);
    pio_pad_model i_pad (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_drive, .ext_oe, .pin_in);

    always #50 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] ad(input logic [3:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    function automatic logic [7:0] pf(input pio_pins_t v, input int p);
        case (p)
            0: return 8'(v.a);
            1: return 8'(v.b);
            2: return 8'(v.c);
            3: return 8'(v.d);
            default: return 8'(v.e);
        endcase
    endfunction

    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        exp_b.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        exp_r.push_back({r, 24'h0, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // takes the oldest note whenever an answer is handed over
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
            chk({s_axi_bresp, 32'h0}, exp_b.pop_front());
        if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0)
            chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    end

    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk(34'(pin_oe), '0);
        foreach (di[p]) rd(ad(di[p]), 8'h00);
        for (int i = 13; i < 16; i++) rd(ad(4'(i)), 8'h00);
        foreach (li[p]) begin
            lat[p] = 8'(rnd());
            wr(ad(li[p]), lat[p]);
            wr(ad(di[p]), 8'hff);
            rd(ad(li[p]), lat[p] & mk[p]);
            rd(ad(di[p]), mk[p]);
        end
        chk(34'(pin_oe), 34'h1fffff);
        chk(34'(pin_out), 34'({lat[4][1:0], lat[3][6:0], lat[2][1:0], lat[1][5:0], lat[0][3:0]}));
        // mid-run reset keeps the latches
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk(34'(pin_oe), '0);
        foreach (li[p]) begin
            wr(ad(di[p]), 8'hff);
            rd(ad(li[p]), lat[p] & mk[p]);
        end
        // all inputs, driven from outside
        ext_drive <= pio_pins_t'(21'(rnd()));
        ext_oe <= '1;
        foreach (di[p]) wr(ad(di[p]), 8'h00);
        repeat (6) @(posedge aclk);
        chk(34'(pin_level), 34'(ext_drive));
        foreach (li[p]) rd(ad(li[p]), pf(ext_drive, p));
        wr(ad(4'h4), 8'h05);
        rd(ad(4'h0), lat[0] & 8'h05 | pf(ext_drive, 0) & 8'h0a);
        // pullups with nothing driving outside
        ext_oe <= '0;
        for (int i = 13; i < 16; i++) wr(ad(4'(i)), 8'hff);
        rd(ad(4'hd), 8'h0f);
        rd(ad(4'he), 8'h03);
        rd(ad(4'hf), 8'h7f);
        repeat (6) @(posedge aclk);
        chk(34'(pin_pullup), 34'({2'h0, 7'h7f, 2'h3, 6'h0, 4'ha}));
        rd(ad(4'h3), 8'h7f);
        rd(ad(4'h0), lat[0] & 8'h05 | 8'h0a);
        wr(ad(4'h4), 8'h00);
        s_axi_wstrb <= 4'h0;
        wr(ad(4'h4), 8'hff);
        s_axi_wstrb <= 4'hf;
        repeat (2) @(posedge aclk);
        chk(34'(pin_pullup.a), 34'h0f);
        foreach (bad[i]) begin
            wr(bad[i], 8'hff, PIO_RESP_SLVERR);
            rd(bad[i], 8'h00, PIO_RESP_SLVERR);
        end
        // every pin an output, then peripherals take over
        foreach (di[p]) wr(ad(di[p]), 8'hff);
        periph_oe <= pio_pins_t'(21'(rnd()));
        periph_out <= pio_pins_t'(21'(rnd()));
        periph_ctl.keyboard_irq_pin_enable <= 4'h9;
        periph_ctl.spi_module_enable <= 1'b1;
        periph_ctl.timer_ch0_edge_select <= 2'h1;
        periph_ctl.timer_ch1_edge_select <= 2'h2;
        periph_ctl.timer_two_ch0_edge_select <= 2'h3;
        periph_ctl.sci_module_enable <= 1'b1;
        periph_ctl.adc_active <= 1'b1;
        for (int c = 0; c < 6; c++) begin
            periph_ctl.adc_channel_select <= 3'(c);
            repeat (2) @(posedge aclk);
            chk(34'(pin_oe.b), 34'(6'h3f & ~(6'h1 << c)));
        end
        chk(34'(pin_oe.a), 34'h6);
        chk(34'(pin_pullup.a), '0);
        chk(34'({pin_oe.e, pin_oe.d}), 34'({periph_oe.e, periph_oe.d}));
        chk(34'({pin_out.e, pin_out.d}), 34'({periph_out.e & periph_oe.e, periph_out.d & periph_oe.d}));
        repeat (3) @(posedge aclk);
        close_out();
    end
endmodule
